// File: verilog/cld_regs.vh
`ifndef CLD_REGS_VH
`define CLD_REGS_VH

// ----------------------------------------------------------------
// Word and frame geometry
// ----------------------------------------------------------------
`define CLD_WORD_BITS     16
`define CLD_CNT_BITS      9
// Oversampling clocks per bit cell
`define CLD_CELL_CLKS     9'h010
// Clock count of the start bit centre
`define CLD_START_SAMPLE  9'h008
// Clock count of the first (most significant) data sample
`define CLD_FIRST_SAMPLE  9'h018
// Clock count of the last (least significant) data sample
`define CLD_LAST_SAMPLE   9'h108
// Clock count of the stop bit sample
`define CLD_STOP_SAMPLE   9'h118
// Low nibble shared by every data sample count
`define CLD_SAMPLE_PHASE  4'h8

// ----------------------------------------------------------------
// Range select codes
// ----------------------------------------------------------------
`define CLD_RANGE_V0_5    2'h0
`define CLD_RANGE_I4_20   2'h1
`define CLD_RANGE_I0_20   2'h2
`define CLD_RANGE_I0_24   2'h3

// ----------------------------------------------------------------
// Reset values and buffering
// ----------------------------------------------------------------
`define CLD_CODE_RESET    16'h0000
// Synchroniser reset {strobe, data, link clock, clear, range}: idle pin levels
`define CLD_SYNC_RESET    6'h30
`define CLD_FIFO_DEPTH    16

`endif

// File: verilog/cld_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Word FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module cld_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // Fill side
  input  wire             wr_valid,
  output wire             wr_ready,
  input  wire [WIDTH-1:0] wr_data,
  // Drain side
  output wire             rd_valid,
  input  wire             rd_ready,
  output wire [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];  // Word storage
  reg [AW-1:0]    wr_ptr_reg;           // Next slot to fill
  reg [AW-1:0]    rd_ptr_reg;           // Next slot to drain
  reg [AW:0]      count_reg;            // Words held
  wire            push;                 // Accepted write
  wire            pop;                  // Accepted read

  assign wr_ready = (count_reg != DEPTH[AW:0]);
  assign rd_valid = (count_reg != {(AW+1){1'b0}});
  assign rd_data  = mem_reg[rd_ptr_reg];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  // Pointer wrap for any depth
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      ptr_inc = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  // Storage write
  always @(posedge ref_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= wr_data;
  end

  // Pointers and occupancy
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: verilog/cld_serial.v
// Function
// - Range pins pick 0-5V, 4-20, 0-20, 0-24.
// - Clear holds output at bottom of span.
// - Async word framed by start 0, stop 1.
// - Async samples at bit cell centre edge.
// - Each async bit cell is sixteen clocks.
// - Start cell counts from first clock after fall.
// - MSB at clock 24, then every sixteen.
// - Valid stop bit transfers word to output.
// - Bad stop gives one-clock high output pulse.
// - Framing error discards word, output unchanged.
// - Strobe rising edge loads word; high means async.
// - Three-wire mode shifts data out for chaining.
// - Clear keeps input register; bottom until reload.
`timescale 1ns/1ps
`default_nettype none
`include "cld_regs.vh"

module cld_serial #(
  parameter WORD_BITS  = `CLD_WORD_BITS,
  parameter FIFO_DEPTH = `CLD_FIFO_DEPTH
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 rst_n,
  // Serial pins from the host
  input  wire                 link_clk,
  input  wire                 ser_din,
  input  wire                 load_strobe,
  // Control pins
  input  wire                 clear_in,
  input  wire [1:0]           range_sel,
  // Serial output pin
  output reg                  ser_dout,
  // Converter side
  output reg  [WORD_BITS-1:0] dac_code,
  output reg  [3:0]           span_onehot,
  output reg                  at_bottom
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [5:0] meta_reg;    // First stage, read only by second stage
  reg [5:0] sync_reg;    // Second stage
  reg       clk_d_reg;   // Delayed link clock for edge finding
  reg       stb_d_reg;   // Delayed strobe for edge finding

  // Two flops on every pin input
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      meta_reg  <= `CLD_SYNC_RESET;
      sync_reg  <= `CLD_SYNC_RESET;
      clk_d_reg <= 1'b0;
      stb_d_reg <= 1'b1;
    end
    else
    begin
      meta_reg  <= {load_strobe, ser_din, link_clk, clear_in, range_sel};
      sync_reg  <= meta_reg;
      clk_d_reg <= sync_reg[3];
      stb_d_reg <= sync_reg[5];
    end
  end

  wire [1:0] range_s = sync_reg[1:0];      // Range selection
  wire       clr_s   = sync_reg[2];        // Clear level
  wire       lclk_s  = sync_reg[3];        // Link clock level
  wire       din_s   = sync_reg[4];        // Serial data level
  wire       stb_s   = sync_reg[5];        // Load strobe level
  wire       lclk_rise = lclk_s & ~clk_d_reg;   // Link clock rising edge
  wire       stb_rise  = stb_s & ~stb_d_reg;    // Strobe rising edge

  // ----------------------------------------------------------------
  // Range decode
  // ----------------------------------------------------------------
  function [3:0] span_dec;
    input [1:0] code;
    begin
      case (code)
        `CLD_RANGE_V0_5:  span_dec = 4'h1;
        `CLD_RANGE_I4_20: span_dec = 4'h2;
        `CLD_RANGE_I0_20: span_dec = 4'h4;
        default:          span_dec = 4'h8;
      endcase
    end
  endfunction

  // Registered span outputs
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      span_onehot <= span_dec(`CLD_RANGE_V0_5);
    else
      span_onehot <= span_dec(range_s);
  end

  // ----------------------------------------------------------------
  // Three-wire shift register
  // ----------------------------------------------------------------
  reg [WORD_BITS-1:0] shift_reg;   // Input register, kept through clear

  // Shift MSB first on each link rising edge while strobe is low
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      shift_reg <= {WORD_BITS{1'b0}};
    else if (lclk_rise && !stb_s)
      shift_reg <= {shift_reg[WORD_BITS-2:0], din_s};
  end

  // ----------------------------------------------------------------
  // Asynchronous frame receiver
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'b01;   // Waiting for a start bit
  localparam ST_FRAME = 2'b10;   // Counting through a frame

  reg [1:0]                  state_reg;    // Receiver state
  reg [`CLD_CNT_BITS-1:0]    cnt_reg;      // Clocks since start began
  reg [WORD_BITS-1:0]        rx_reg;       // Received data bits
  reg                        ferr_reg;     // Framing pulse in progress
  reg                        armed_reg;    // Line seen high while idle
  reg                        rx_done;      // Valid frame this cycle
  wire [`CLD_CNT_BITS-1:0]   cnt_next = cnt_reg + 1'b1;

  // Data sample points lie on the cell centres from 24 to 264
  wire data_pt = (cnt_next >= `CLD_FIRST_SAMPLE) && (cnt_next <= `CLD_LAST_SAMPLE)
               && (cnt_next[3:0] == `CLD_SAMPLE_PHASE);

  // Frame state machine, stepped by link clock edges
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= {`CLD_CNT_BITS{1'b0}};
      rx_reg    <= {WORD_BITS{1'b0}};
      ferr_reg  <= 1'b0;
      rx_done   <= 1'b0;
      armed_reg <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      // A start needs a falling edge: a low stop cell must not restart
      if (din_s && state_reg == ST_IDLE)
        armed_reg <= 1'b1;
      if (lclk_rise)
      begin
        ferr_reg <= 1'b0;   // Error pulse ends after one link clock
        case (state_reg)
          ST_IDLE:
          begin
            // First clock after the falling edge is clock one
            if (stb_s && !din_s && armed_reg)
            begin
              state_reg <= ST_FRAME;
              cnt_reg   <= 9'h001;
              armed_reg <= 1'b0;
            end
          end
          ST_FRAME:
          begin
            cnt_reg <= cnt_next;
            if (!stb_s)
              state_reg <= ST_IDLE;   // Strobe went low: leave async mode
            else if (cnt_next == `CLD_START_SAMPLE && din_s)
              state_reg <= ST_IDLE;   // Glitch, not a real start bit
            else if (data_pt)
              rx_reg <= {rx_reg[WORD_BITS-2:0], din_s};
            else if (cnt_next == `CLD_STOP_SAMPLE)
            begin
              state_reg <= ST_IDLE;
              if (din_s)
                rx_done <= 1'b1;
              else
                ferr_reg <= 1'b1;     // Word dropped
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Async mode shows only the framing pulse; three-wire shows the
  // bit falling off the register top for the next device in chain
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ser_dout <= 1'b0;
    else if (stb_s)
      ser_dout <= ferr_reg;
    else
      ser_dout <= shift_reg[WORD_BITS-1];
  end

  // ----------------------------------------------------------------
  // Word hand-off into the FIFO
  // ----------------------------------------------------------------
  reg                 pend_reg;    // Word waiting for FIFO room
  reg [WORD_BITS-1:0] pend_data;   // That word
  wire                fifo_wr_ready;
  wire                fifo_rd_valid;
  wire [WORD_BITS-1:0] fifo_rd_data;
  wire                fifo_rd_ready = ~clr_s;   // Drain stalls during clear

  // Hold a finished word until the FIFO takes it; a newer word replaces it
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_reg  <= 1'b0;
      pend_data <= {WORD_BITS{1'b0}};
    end
    else if (stb_rise)
    begin
      pend_reg  <= 1'b1;
      pend_data <= shift_reg;
    end
    else if (rx_done)
    begin
      pend_reg  <= 1'b1;
      pend_data <= rx_reg;
    end
    else if (fifo_wr_ready)
      pend_reg <= 1'b0;
  end

  cld_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .wr_valid (pend_reg),
    .wr_ready (fifo_wr_ready),
    .wr_data  (pend_data),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data)
  );

  // ----------------------------------------------------------------
  // Converter code register
  // ----------------------------------------------------------------
  // Clear forces code zero (bottom of any span) and it stays there
  // until a fresh word is drained; the input register is untouched
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      dac_code  <= `CLD_CODE_RESET;
      at_bottom <= 1'b1;
    end
    else if (clr_s)
    begin
      dac_code  <= `CLD_CODE_RESET;
      at_bottom <= 1'b1;
    end
    else if (fifo_rd_valid)
    begin
      dac_code  <= fifo_rd_data;
      at_bottom <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: verif/cld_serial_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the serial block
// ----------------------------------------------------------------
module cld_serial_props #(
  parameter WORD_BITS = 16
) (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  // Pins
  input wire logic                 link_clk,
  input wire logic                 ser_din,
  input wire logic                 load_strobe,
  input wire logic                 clear_in,
  input wire logic [1:0]           range_sel,
  // Outputs
  input wire logic                 ser_dout,
  input wire logic [WORD_BITS-1:0] dac_code,
  input wire logic [3:0]           span_onehot,
  input wire logic                 at_bottom
);
  logic       lk_q;          // Last link clock sample
  logic [3:0] since;         // Clocks since link rise
  // Age of the latest link clock rise, saturating
  always_ff @(posedge ref_clk)
  begin
    lk_q <= link_clk;
    if (!rst_n)
      since <= 4'hF;
    else if (link_clk && !lk_q)
      since <= 4'h0;
    else if (since != 4'hF)
      since <= since + 4'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_span_decode: assert property (
    (rst_n && $stable(range_sel))[*6] |-> span_onehot == (4'h1 << range_sel))
    else $error("span does not match range pins");
  chk_clear_bottom: assert property (
    clear_in[*5] |-> dac_code == '0 && at_bottom)
    else $error("clear did not force bottom");
  chk_bottom_code: assert property (
    at_bottom |-> dac_code == '0)
    else $error("bottom flag with nonzero code");
  chk_bottom_exit: assert property (
    $fell(at_bottom) |-> !clear_in && !$past(clear_in))
    else $error("left bottom while clear high");
  chk_pulse_width: assert property (
    load_strobe && $rose(ser_dout) |-> ser_dout[*7] ##[1:2] !ser_dout)
    else $error("framing pulse width wrong");
  chk_frame_discard: assert property (
    load_strobe && $rose(ser_dout) |-> $stable(dac_code)[*8])
    else $error("code changed on framing error");
  chk_pulse_timing: assert property (
    load_strobe && $rose(ser_dout) |-> since inside {[4'h1:4'h6]})
    else $error("framing pulse not after link rise");
  chk_three_wire_hold: assert property (
    (!load_strobe && !clear_in)[*8] |-> $stable(dac_code))
    else $error("code changed without strobe rise");
endmodule
bind cld_serial cld_serial_props #(.WORD_BITS(WORD_BITS)) u_cld_serial_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .ser_din(ser_din),
  .load_strobe(load_strobe), .clear_in(clear_in), .range_sel(range_sel),
  .ser_dout(ser_dout), .dac_code(dac_code), .span_onehot(span_onehot), .at_bottom(at_bottom));
`default_nettype wire

// File: verif/cld_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host model driving the serial pins
// ----------------------------------------------------------------
module cld_host (
  // Host pins
  output var logic link_clk,
  output var logic ser_din,
  output var logic load_strobe
);
  // Idle: clock still, data high, strobe high
  initial
  begin
    link_clk = 1'b0;
    ser_din = 1'b1;
    load_strobe = 1'b1;
  end
  // One 80 ns link period, low then high
  task automatic tick();
    link_clk = 1'b0;
    #40;
    link_clk = 1'b1;
    #40;
  endtask
  // Shift n bits MSB first, then raise the strobe
  task automatic send3(input logic [31:0] v, input int n);
    load_strobe = 1'b0;
    #80;
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_din = v[i];
      tick();
    end
    link_clk = 1'b0;
    ser_din = ~ser_din;  // Released line keeps no valid level
    #80;
    load_strobe = 1'b1;
  endtask
  // Strobe pulse with no new bits
  task automatic relatch();
    load_strobe = 1'b0;
    #80;
    load_strobe = 1'b1;
  endtask
  // Framed word, sixteen clocks per cell, stop value as commanded
  task automatic send_async(input logic [15:0] w, input logic stop);
    logic [17:0] f;
    f = {1'b0, w, stop};
    ser_din = 1'b1;
    #80;
    for (int c = 17; c >= 0; c--)
    begin
      ser_din = f[c];
      repeat (16) tick();
    end
    link_clk = 1'b0;
    ser_din = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module tb;
  typedef struct packed {
    logic        asy;   // Async frame, else three-wire
    logic [1:0]  rng;   // Range pins
    logic [15:0] word;  // Word sent
    logic        stop;  // Stop bit sent
    logic [15:0] code;  // Code expected
    logic [3:0]  span;  // Span expected
  } cld_row_t;
  cld_row_t rows [5] = '{
    '{1'b0, 2'h0, 16'hA5C3, 1'b1, 16'hA5C3, 4'h1},
    '{1'b1, 2'h1, 16'h8001, 1'b1, 16'h8001, 4'h2},
    '{1'b1, 2'h2, 16'h7FFE, 1'b0, 16'h8001, 4'h4},
    '{1'b0, 2'h3, 16'hFFFF, 1'b1, 16'hFFFF, 4'h8},
    '{1'b1, 2'h3, 16'h4002, 1'b1, 16'h4002, 4'h8}};
  logic        ref_clk = 1'b0;
  logic        rst_n, clear_in, err_seen, dout_q;
  logic [1:0]  range_sel;
  logic [15:0] chain_cap;  // Serial output seen by a downstream device
  wire         link_clk, ser_din, load_strobe, ser_dout, at_bottom;
  wire  [15:0] dac_code;
  wire  [3:0]  span_onehot;
  int          fails, tests_run, cyc;
  cld_host u_cld_host (.link_clk(link_clk), .ser_din(ser_din), .load_strobe(load_strobe));
  cld_serial u_cld_serial (
    .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .ser_din(ser_din),
    .load_strobe(load_strobe), .clear_in(clear_in), .range_sel(range_sel),
    .ser_dout(ser_dout), .dac_code(dac_code), .span_onehot(span_onehot), .at_bottom(at_bottom));
  // 100 MHz clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Downstream device view: chain output taken at each link rise while strobe is low
  always @(posedge link_clk)
  begin
    if (!load_strobe) chain_cap <= {chain_cap[14:0], ser_dout};
  end
  // Framing pulse catcher and hang limit
  always @(posedge ref_clk)
  begin
    dout_q <= ser_dout;
    if (ser_dout === 1'b1 && dout_q === 1'b0 && load_strobe) err_seen <= 1'b1;
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      results();
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic results();
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    clear_in = 1'b0;
    range_sel = 2'h0;
    err_seen = 1'b0;
    wait_clk(20);
    rst_n = 1'b1;
    wait_clk(4);
    check("dac_code", dac_code, 16'h0000);
    check("at_bottom", {15'h0, at_bottom}, 16'h0001);
    check("span", {12'h0, span_onehot}, 16'h0001);
    foreach (rows[i])
    begin
      range_sel = rows[i].rng;
      err_seen = 1'b0;
      if (rows[i].asy) u_cld_host.send_async(rows[i].word, rows[i].stop);
      else u_cld_host.send3({16'h0, rows[i].word}, 16);
      wait_clk(12);
      check("dac_code", dac_code, rows[i].code);
      check("span", {12'h0, span_onehot}, {12'h0, rows[i].span});
      check("frame_err", {15'h0, err_seen}, {15'h0, ~rows[i].stop});
    end
    // Long stream: leading bits fall out toward the chain
    u_cld_host.send3(32'h0005_1234, 20);
    wait_clk(12);
    check("chain", dac_code, 16'h1234);
    // Old word 16'hFFFF leaves first, then the leading bits 0101
    check("chain_out", chain_cap, 16'hFFF5);
    // Clear forces bottom, then holds it after release
    clear_in = 1'b1;
    wait_clk(6);
    check("clr_code", dac_code, 16'h0000);
    clear_in = 1'b0;
    wait_clk(10);
    check("clr_hold", {15'h0, at_bottom}, 16'h0001);
    check("clr_code", dac_code, 16'h0000);
    // Input register survived the clear
    u_cld_host.relatch();
    wait_clk(12);
    check("reload", dac_code, 16'h1234);
    // Reset in mid-run returns the output to bottom of span
    rst_n = 1'b0;
    wait_clk(3);
    rst_n = 1'b1;
    wait_clk(4);
    check("rst_code", dac_code, 16'h0000);
    check("rst_bottom", {15'h0, at_bottom}, 16'h0001);
    results();
  end
endmodule
`default_nettype wire
